/* File: rpsc_pkg.sv */
// Constants for the root port status and control block.
// Assumes a 32-bit AXI4-Lite register bus and a 100 MHz clock.

package rpsc_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / 8;
  localparam logic [AXI_ADDR_W-1:0] PORT_OFS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [AXI_DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ************************************************************
  // Port register fields
  // ************************************************************
  localparam int CONNECT_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int SUSPEND_BIT = 2;
  localparam int RESET_BIT = 4;
  localparam int POWER_BIT = 8;
  localparam int SPEED_BIT = 9;
  localparam int CHANGE_BIT = 16;

  // ************************************************************
  // Interrupt status and mask layout
  // ************************************************************
  localparam int IRQ_W = 2;
  localparam int IRQ_CONNECT_BIT = 0;
  localparam int IRQ_RESET_DONE_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 2'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int RESET_TIME_MS = 10;
  localparam int RESET_CYCLES = RESET_TIME_MS * 1000 * CLK_MHZ;
  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 32;

endpackage

/* File: rpsc_port.sv */
// Status and control logic for one downstream root hub port, AXI4-Lite slave.
// Assumes the enable and suspend status come from port logic on aclk; the
// connect and speed lines come from the port pins, asynchronous to aclk.
//
// Overview of operation
// - Connect or disconnect sets the connect-change flag.
// - Reset, enable or suspend request while disconnected sets change flag instead.
// - Speed bit means something only while connected.
// - Speed bit reads 0 full-speed, 1 low-speed.
// - Writing 1 to bit 9 clears power.
// - Writing 1 to bit 8 sets power.
// - Bit 8 reads the power status.
// - Power status is tracked only, drives nothing.
// - Writing 1 to bit 4 starts reset signaling.
// - Writing 1 to bit 16 clears change flag.
// - Reset status reads 1 while reset signaling runs.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.

`timescale 1ns/100ps
`default_nettype none

module rpsc_port #(
  parameter int RESET_CYCLES = rpsc_pkg::RESET_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rpsc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [rpsc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [rpsc_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rpsc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [rpsc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dev_connect_pin,
  input wire logic dev_low_speed_pin,
  input wire logic port_enable_status,
  input wire logic port_suspend_status,
  output logic current_connect,
  output logic usb_reset_drive,
  output logic set_enable_req,
  output logic set_suspend_req,
  output logic irq
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [rpsc_pkg::SYNC_STAGES-1:0] conn_sync_reg;
  logic [rpsc_pkg::SYNC_STAGES-1:0] speed_sync_reg;
  logic connect_reg;
  logic low_speed_reg;
  logic conn_change_evt;

  // Stage 0 feeds stage 1 only; a level counts once stages 1 and 2 agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conn_sync_reg <= '0;
      speed_sync_reg <= '0;
    end
    else
    begin
      conn_sync_reg <= {conn_sync_reg[1:0], dev_connect_pin};
      speed_sync_reg <= {speed_sync_reg[1:0], dev_low_speed_pin};
    end
  end

  assign conn_change_evt = (conn_sync_reg[1] == conn_sync_reg[2]) &&
                           (conn_sync_reg[2] != connect_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      connect_reg <= 1'b0;
    else if (conn_change_evt)
      connect_reg <= conn_sync_reg[2];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_speed_reg <= 1'b0;
    else if (speed_sync_reg[1] == speed_sync_reg[2])
      low_speed_reg <= speed_sync_reg[2];
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic aw_have_reg;
  logic w_have_reg;
  logic [rpsc_pkg::AXI_ADDR_W-1:0] aw_addr_reg;
  logic [rpsc_pkg::AXI_DATA_W-1:0] w_data_reg;
  logic [rpsc_pkg::AXI_DATA_W-1:0] w_mask;
  logic wr_fire;
  logic wr_port;
  logic wr_stat;
  logic wr_mask;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_have_reg <= 1'b0;
    else if (!aw_have_reg && !s_axi_bvalid)
      s_axi_awready <= 1'b1;
  end

  // Byte lanes without a strobe write zeros, which every field ignores except the IRQ mask, which loads them
  generate
    for (genvar i = 0; i < rpsc_pkg::AXI_STRB_W; i++)
    begin : g_lane
      assign w_mask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata & w_mask;
    end
    else if (wr_fire)
      w_have_reg <= 1'b0;
    else if (!w_have_reg && !s_axi_bvalid)
      s_axi_wready <= 1'b1;
  end

  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wr_port = wr_fire && (aw_addr_reg == rpsc_pkg::PORT_OFS);
  assign wr_stat = wr_fire && (aw_addr_reg == rpsc_pkg::IRQ_STAT_OFS);
  assign wr_mask = wr_fire && (aw_addr_reg == rpsc_pkg::IRQ_MASK_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rpsc_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_port || wr_stat || wr_mask) ? rpsc_pkg::RESP_OKAY :
                     rpsc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Port control state
  // ************************************************************
  logic change_reg;
  logic power_reg;
  logic reset_reg;
  logic [rpsc_pkg::CNT_W-1:0] reset_cnt_reg;
  logic reset_done;
  logic refused_req;
  logic change_set;
  logic reset_start;

  // A reset, enable or suspend request while disconnected is turned into a change report
  assign refused_req = wr_port && !connect_reg &&
                       (w_data_reg[rpsc_pkg::RESET_BIT] ||
                        w_data_reg[rpsc_pkg::ENABLE_BIT] ||
                        w_data_reg[rpsc_pkg::SUSPEND_BIT]);
  assign change_set = conn_change_evt || refused_req;

  // Set beats the software clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      change_reg <= 1'b0;
    else if (change_set)
      change_reg <= 1'b1;
    else if (wr_port && w_data_reg[rpsc_pkg::CHANGE_BIT])
      change_reg <= 1'b0;
  end

  // Bookkeeping only: nothing leaves the block to switch real port power
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_reg <= 1'b0;
    else if (wr_port && w_data_reg[rpsc_pkg::SPEED_BIT])
      power_reg <= 1'b0;
    else if (wr_port && w_data_reg[rpsc_pkg::POWER_BIT])
      power_reg <= 1'b1;
  end

  assign reset_done = reset_reg &&
                      (reset_cnt_reg == rpsc_pkg::CNT_W'(RESET_CYCLES - 1));
  assign reset_start = wr_port && connect_reg && !reset_reg &&
                       w_data_reg[rpsc_pkg::RESET_BIT];

  // A second start request during signaling does not restart the timer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_reg <= 1'b0;
      reset_cnt_reg <= '0;
    end
    else if (reset_done)
    begin
      reset_reg <= 1'b0;
      reset_cnt_reg <= '0;
    end
    else if (reset_reg)
      reset_cnt_reg <= reset_cnt_reg + 1'b1;
    else if (reset_start)
      reset_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      usb_reset_drive <= 1'b0;
      current_connect <= 1'b0;
      set_enable_req <= 1'b0;
      set_suspend_req <= 1'b0;
    end
    else
    begin
      // Tracks the status bit exactly: never shows 0 while reset is on the pins
      usb_reset_drive <= (reset_reg && !reset_done) || reset_start;
      current_connect <= connect_reg;
      set_enable_req <= wr_port && connect_reg && w_data_reg[rpsc_pkg::ENABLE_BIT];
      set_suspend_req <= wr_port && connect_reg && w_data_reg[rpsc_pkg::SUSPEND_BIT];
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic [rpsc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [rpsc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [rpsc_pkg::IRQ_W-1:0] irq_set;
  logic [rpsc_pkg::IRQ_W-1:0] irq_clr;

  assign irq_set[rpsc_pkg::IRQ_CONNECT_BIT] = change_set;
  assign irq_set[rpsc_pkg::IRQ_RESET_DONE_BIT] = reset_done;
  assign irq_clr = wr_stat ? w_data_reg[rpsc_pkg::IRQ_W-1:0] : rpsc_pkg::IRQ_ZERO;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_reg <= rpsc_pkg::IRQ_ZERO;
    else
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_reg <= rpsc_pkg::IRQ_ZERO;
    else if (wr_mask)
      irq_mask_reg <= w_data_reg[rpsc_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic [rpsc_pkg::AXI_DATA_W-1:0] rdata_next;
  logic rd_hit;

  always_comb
  begin
    rdata_next = rpsc_pkg::DATA_ZERO;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      rpsc_pkg::PORT_OFS:
      begin
        rdata_next[rpsc_pkg::CONNECT_BIT] = connect_reg;
        rdata_next[rpsc_pkg::ENABLE_BIT] = port_enable_status;
        rdata_next[rpsc_pkg::SUSPEND_BIT] = port_suspend_status;
        rdata_next[rpsc_pkg::RESET_BIT] = reset_reg;
        rdata_next[rpsc_pkg::POWER_BIT] = power_reg;
        // Speed is only meaningful while connected, so it reads 0 otherwise
        rdata_next[rpsc_pkg::SPEED_BIT] = low_speed_reg && connect_reg;
        rdata_next[rpsc_pkg::CHANGE_BIT] = change_reg;
      end
      rpsc_pkg::IRQ_STAT_OFS:
        rdata_next[rpsc_pkg::IRQ_W-1:0] = irq_stat_reg;
      rpsc_pkg::IRQ_MASK_OFS:
        rdata_next[rpsc_pkg::IRQ_W-1:0] = irq_mask_reg;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= rpsc_pkg::DATA_ZERO;
      s_axi_rresp <= rpsc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rd_hit ? rpsc_pkg::RESP_OKAY : rpsc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

endmodule

`default_nettype wire

/* File: rpsc_port_properties.sv */
// Checker for rpsc_port: bus answers and port reset timing.
// Assumes it is bound to rpsc_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module rpsc_port_props #(
  parameter int RESET_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic current_connect,
  input wire logic usb_reset_drive,
  input wire logic set_enable_req,
  input wire logic set_suspend_req
);
  logic [31:0] run_cnt;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ********************
  // Sequences
  // ********************
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence port_w(b);
    aw_w_take ##0 (s_axi_awaddr == rpsc_pkg::PORT_OFS && s_axi_wdata[b]);
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Length of the running reset pulse, zero while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !usb_reset_drive)
      run_cnt <= 32'h0;
    else
      run_cnt <= run_cnt + 32'h1;
  end
  a_write_answer: assert property (aw_w_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_unmapped_read: assert property (ar_take ##0 s_axi_araddr > 8'h08
    |=> s_axi_rresp == rpsc_pkg::RESP_SLVERR && s_axi_rdata == rpsc_pkg::DATA_ZERO)
    else $error("unmapped read answered");
  a_reset_start: assert property (
    port_w(4) ##0 current_connect && !usb_reset_drive |-> ##[1:2] usb_reset_drive)
    else $error("reset signaling not started");
  a_reset_refused: assert property (
    port_w(4) ##0 !current_connect && !usb_reset_drive |=> !usb_reset_drive [*3])
    else $error("reset started while disconnected");
  a_enable_refused: assert property (
    port_w(1) ##0 !current_connect |=> !set_enable_req [*2])
    else $error("enable request while disconnected");
  a_suspend_refused: assert property (
    port_w(2) ##0 !current_connect |=> !set_suspend_req [*2])
    else $error("suspend request while disconnected");
  a_enable_pulse: assert property (
    port_w(1) ##0 current_connect |-> ##2 set_enable_req)
    else $error("enable request not passed on");
  a_speed_idle: assert property (
    s_axi_rvalid && !s_axi_rdata[0] |-> !s_axi_rdata[9])
    else $error("speed shown while disconnected");
  a_reset_length: assert property (
    $fell(usb_reset_drive) |-> $past(run_cnt) == RESET_CYCLES - 1)
    else $error("reset pulse length wrong");
  a_reset_bounded: assert property (
    usb_reset_drive |-> run_cnt < RESET_CYCLES)
    else $error("reset pulse too long");
endmodule
bind rpsc_port rpsc_port_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .current_connect, .usb_reset_drive,
  .set_enable_req, .set_suspend_req);
`default_nettype wire

/* File: rpsc_usb_dev.sv */
// Device model on the port pins; measures the reset pulse it receives.
// Assumes attach and low are driven on aclk edges.
`timescale 1ns/100ps
`default_nettype none
module rpsc_usb_dev (
  input wire logic aclk,
  input wire logic attach,
  input wire logic low,
  input wire logic usb_reset_drive,
  output logic connect_pin,
  output logic speed_pin,
  output var int rst_len
);
  int cnt = 0;
  assign connect_pin = attach;
  // Pulled down once detached, so no stale speed level
  assign speed_pin = attach & low;
  initial rst_len = 0;
  always @(posedge aclk)
  begin
    if (usb_reset_drive)
      cnt++;
    else if (cnt != 0)
    begin
      rst_len = cnt;
      cnt = 0;
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Testbench for rpsc_port with a device model on the port pins.
// Assumes rpsc_pkg, the checker and the device model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int RST_N = 8;
  logic aclk = 1'h0, aresetn = 1'h0, attach = 1'h0, low = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic current_connect, usb_reset_drive, irq, pin_c, pin_s;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int rst_len, fails = 0, checks = 0, cyc = 0;
  logic [31:0] row_w[7] = '{32'h100, 32'h0, 32'h6, 32'h200, 32'h100, 32'h300, 32'h10};
  logic [31:0] row_e[7] = '{32'h301, 32'h301, 32'h301, 32'h201, 32'h301, 32'h201, 32'h211};
  always #5 aclk = ~aclk;
  rpsc_port #(.RESET_CYCLES(RST_N)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dev_connect_pin(pin_c), .dev_low_speed_pin(pin_s),
    .port_enable_status(1'h0), .port_suspend_status(1'h0), .current_connect,
    .usb_reset_drive, .set_enable_req(), .set_suspend_req(), .irq);
  rpsc_usb_dev u_dev (.aclk, .attach, .low, .usb_reset_drive,
    .connect_pin(pin_c), .speed_pin(pin_s), .rst_len);
  // ********************
  // Bus tasks and checks
  // ********************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd(rpsc_pkg::PORT_OFS);
    chk("port reset", 32'h0, d);
    attach <= 1'h1;
    repeat (12) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("connect out", 32'h1, {31'h0, current_connect});
    rd(rpsc_pkg::PORT_OFS);
    chk("attach low", 32'h0001_0201, d);
    wr(rpsc_pkg::IRQ_MASK_OFS, 32'h1);
    chk("wr resp", {30'h0, rpsc_pkg::RESP_OKAY}, {30'h0, r});
    repeat (2) @(posedge aclk);
    chk("irq up", 32'h1, {31'h0, irq});
    wr(rpsc_pkg::PORT_OFS, 32'h0001_0000);
    wr(rpsc_pkg::IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq down", 32'h0, {31'h0, irq});
    $display("test irq done");
    for (int i = 0; i < 7; i++)
    begin
      wr(rpsc_pkg::PORT_OFS, row_w[i]);
      rd(rpsc_pkg::PORT_OFS);
      chk("row", row_e[i], d);
    end
    while (usb_reset_drive !== 1'h0) @(posedge aclk);
    @(posedge aclk);
    rd(rpsc_pkg::PORT_OFS);
    chk("reset end", 32'h201, d);
    chk("reset len", RST_N, rst_len);
    rd(rpsc_pkg::IRQ_STAT_OFS);
    chk("reset done irq", 32'h2, d);
    $display("test rows done");
    attach <= 1'h0;
    repeat (12) @(posedge aclk);
    rd(rpsc_pkg::PORT_OFS);
    chk("detach", 32'h0001_0000, d);
    wr(rpsc_pkg::PORT_OFS, 32'h0001_0000);
    rd(rpsc_pkg::PORT_OFS);
    chk("change clear", 32'h0, d);
    wr(rpsc_pkg::PORT_OFS, 32'h16);
    rd(rpsc_pkg::PORT_OFS);
    chk("set refused", 32'h0001_0000, d);
    chk("no drive", 32'h0, {31'h0, usb_reset_drive});
    rd(8'h0c);
    chk("unmapped", {30'h0, rpsc_pkg::RESP_SLVERR}, {30'h0, r});
    wr(8'h0c, 32'h0);
    chk("unmapped wr", {30'h0, rpsc_pkg::RESP_SLVERR}, {30'h0, r});
    low <= 1'h0;
    attach <= 1'h1;
    repeat (12) @(posedge aclk);
    rd(rpsc_pkg::PORT_OFS);
    chk("attach full", 32'h0001_0001, d);
    $display("test detach done");
    end_of_test();
  end
endmodule
`default_nettype wire
